// ---- verilog/dte_port_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef DTE_PORT_REGS_SVH
`define DTE_PORT_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define REG_LEAD_CFG 8'h00
`define REG_APPLY 8'h04
`define REG_STATUS 8'h08
`define REG_PROF_MODE 8'h0c
`define REG_PROF_TIME0 8'h10
`define REG_PROF_TIME1 8'h14
`define REG_TOD 8'h18
`define REG_MAN_PORT0 8'h20
`define REG_PROF0_PORT0 8'h30
`define REG_PROF1_PORT0 8'h40
`define REG_LAST 8'h4c

// ==========================================================
// Field positions
`define APPLY_BIT 0
`define PORT_EN_BIT 8
`define TIME_HH_LSB 16
`define TIME_MM_LSB 8
`define TIME_SS_LSB 0
`define PROF_MASTER_BIT 2

// ==========================================================
// Reset values and limits
`define LEAD_CFG_RST 7'h00
`define PROF_MODE_RST 2'h0
`define PORT_BLOCKS_RST 8'h01
`define BLOCKS_MIN 8'h01
`define BLOCKS_MAX 8'h8c

// ==========================================================
// Timing
`define CLK_SYS_HZ 32'h02faf080
`define CLK_PERIOD_NS 20
`define APPLY_HOLD_NS 320
`define APPLY_HOLD_CYC \
    ((`APPLY_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PORT_CLK_HALF_NS 80
`define PORT_CLK_HALF_CYC (`PORT_CLK_HALF_NS / `CLK_PERIOD_NS)
`define TOD_SEC_S 1
`define TOD_SEC_CYC (`TOD_SEC_S * `CLK_SYS_HZ)

`endif

// ---- verilog/dte_port_pkg.sv ----
// Types shared by the port lead and profile logic
package dte_port_pkg;

    // ==========================================================
    // Configuration types
    typedef enum logic [1:0] {DSR_FORCED, DSR_OUTAGE, DSR_TEST, DSR_BOTH}
        dsr_mode_t;
    typedef enum logic [1:0] {TXC_NORMAL, TXC_INVERT, TXC_EXTERNAL}
        txclk_t;
    typedef enum logic [1:0] {PM_TIMED, PM_FORCE0, PM_FORCE1, PM_OFF}
        prof_mode_t;
    typedef enum logic {ST_RUN, ST_HOLD} apply_st_t;

    typedef struct packed {
        txclk_t txclk;
        logic dcd_outage;
        dsr_mode_t dsr_mode;
        logic rdy_idle;
        logic cs_follow;
    } lead_cfg_t;

    typedef struct packed {
        logic enable;
        logic [7:0] blocks;
    } port_cfg_t;

    typedef struct packed {
        logic [4:0] hh;
        logic [5:0] mm;
        logic [5:0] ss;
    } tod_t;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic dcd;
    } leads_t;

    // ==========================================================
    // Module state records
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
    } sync_st_t;

    typedef struct packed {
        logic [25:0] pre;
        tod_t tod;
        logic tick;
    } tod_st_t;

endpackage : dte_port_pkg

// ---- verilog/dte_sync_edge.sv ----
// Two-stage synchroniser with edge detection for the port pins
module dte_sync_edge (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [3:0] pin_i,
    output logic [3:0] level_o,
    output logic [3:0] rise_o,
    output logic [3:0] fall_o
);

    dte_port_pkg::sync_st_t st;
    dte_port_pkg::sync_st_t next_st;

    // Shift chain; only s2 and s3 feed logic
    always_comb
    begin
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign level_o = st.s2;
    assign rise_o = st.s2 & ~st.s3;
    assign fall_o = ~st.s2 & st.s3;

endmodule : dte_sync_edge

// ---- verilog/dte_tod_clock.sv ----
// Time-of-day clock in hours, minutes and seconds
`include "dte_port_regs.svh"
module dte_tod_clock #(
    parameter int SEC_CYCLES = `TOD_SEC_CYC
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic load_i,
    input dte_port_pkg::tod_t load_val_i,
    output dte_port_pkg::tod_t tod_o,
    output logic tick_o
);

    dte_port_pkg::tod_st_t st;
    dte_port_pkg::tod_st_t next_st;

    // Prescaler and wrapping seconds/minutes/hours counter
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (load_i)
        begin
            next_st.pre = '0;
            next_st.tod = load_val_i;
        end
        else if (st.pre == 26'(SEC_CYCLES - 1))
        begin
            next_st.pre = '0;
            next_st.tick = 1'b1; // Stands with the new time value
            if (st.tod.ss < 6'h3b)
                next_st.tod.ss = st.tod.ss + 6'h01;
            else
            begin
                next_st.tod.ss = '0;
                if (st.tod.mm < 6'h3b)
                    next_st.tod.mm = st.tod.mm + 6'h01;
                else
                begin
                    next_st.tod.mm = '0;
                    if (st.tod.hh < 5'h17)
                        next_st.tod.hh = st.tod.hh + 5'h01;
                    else
                        next_st.tod.hh = '0;
                end
            end
        end
        else
            next_st.pre = st.pre + 26'h0000001;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign tod_o = st.tod;
    assign tick_o = st.tick;

endmodule : dte_tod_clock

// ---- verilog/dte_port_leads.sv ----
// Serial port lead control, settings apply and timed profiles
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`include "dte_port_regs.svh"

module dte_port_leads #(
    parameter int SEC_CYCLES = `TOD_SEC_CYC
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic request_to_send_lead_i,
    input wire logic terminal_ready_lead_i,
    input wire logic tx_clk_ext_i,
    input wire logic txd_i,
    input wire logic network_out_of_service_i,
    input wire logic network_out_of_frame_i,
    input wire logic test_active_i,
    input wire logic sync_ok_i,
    output logic clear_to_send_lead_o,
    output logic set_ready_lead_o,
    output logic carrier_detect_lead_o,
    output logic tx_clk_o,
    output logic txd_bit_o,
    output logic txd_valid_o,
    output logic port_traffic_o,
    output dte_port_pkg::port_cfg_t [3:0] port_cfg_o
);

    // ==========================================================
    // State record
    typedef struct packed {
        dte_port_pkg::apply_st_t fsm;
        logic [4:0] hold;
        dte_port_pkg::lead_cfg_t pend_lead;
        dte_port_pkg::lead_cfg_t cur_lead;
        dte_port_pkg::port_cfg_t [3:0] pend_port;
        dte_port_pkg::port_cfg_t [3:0] cur_port;
        dte_port_pkg::port_cfg_t [1:0][3:0] prof;
        dte_port_pkg::tod_t [1:0] prof_time;
        dte_port_pkg::prof_mode_t prof_mode;
        logic master;
        logic active_prof;
        logic prof_on;
        dte_port_pkg::port_cfg_t [3:0] eff_port;
        logic [2:0] div;
        logic int_clk;
        dte_port_pkg::leads_t leads;
        logic traffic;
        logic txd_bit;
        logic txd_valid;
        logic [31:0] rdata;
        logic err;
    } ctl_st_t;

    ctl_st_t st;
    ctl_st_t next_st;

    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    dte_port_pkg::tod_t tod;
    logic tod_tick;
    logic tod_load;
    logic bus_setup;
    logic bus_wr;
    logic apply_wr;
    logic outage;
    logic int_rise;
    logic int_fall;
    logic port_tick;
    logic sample_tick;

    // ==========================================================
    // Helper functions
    function automatic logic [7:0] clamp_blocks(input logic [7:0] b);
        if (b < `BLOCKS_MIN)
            return `BLOCKS_MIN;
        else if (b > `BLOCKS_MAX)
            return `BLOCKS_MAX;
        else
            return b;
    endfunction : clamp_blocks

    function automatic dte_port_pkg::port_cfg_t to_port(
        input logic [31:0] w);
        dte_port_pkg::port_cfg_t p;
        p.enable = w[`PORT_EN_BIT];
        p.blocks = clamp_blocks(w[7:0]);
        return p;
    endfunction : to_port

    function automatic logic [31:0] from_port(
        input dte_port_pkg::port_cfg_t p);
        return {23'h000000, p.enable, p.blocks};
    endfunction : from_port

    function automatic logic [31:0] from_time(input dte_port_pkg::tod_t t);
        return {11'h000, t.hh, 2'h0, t.mm, 2'h0, t.ss};
    endfunction : from_time

    function automatic dte_port_pkg::tod_t to_time(input logic [31:0] w);
        dte_port_pkg::tod_t t;
        t.hh = w[`TIME_HH_LSB +: 5];
        t.mm = w[`TIME_MM_LSB +: 6];
        t.ss = w[`TIME_SS_LSB +: 6];
        return t;
    endfunction : to_time

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `REG_LAST) && (a != 8'h1c);
    endfunction : addr_ok

    // ==========================================================
    // Pin synchroniser and time-of-day clock
    dte_sync_edge u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .pin_i({txd_i, tx_clk_ext_i, terminal_ready_lead_i,
                request_to_send_lead_i}),
        .level_o(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    dte_tod_clock #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_tod (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .load_i(tod_load),
        .load_val_i(to_time(pwdata)),
        .tod_o(tod),
        .tick_o(tod_tick)
    );

    // ==========================================================
    // Bus strobes and clock edges
    assign bus_setup = psel && !penable;
    assign bus_wr = psel && penable && pwrite && !st.err;
    assign apply_wr = bus_wr && (paddr == `REG_APPLY) &&
        pwdata[`APPLY_BIT];
    assign tod_load = bus_wr && (paddr == `REG_TOD);
    assign outage = network_out_of_service_i || network_out_of_frame_i;
    assign int_rise = (st.div == 3'(`PORT_CLK_HALF_CYC - 1)) && !st.int_clk;
    assign int_fall = (st.div == 3'(`PORT_CLK_HALF_CYC - 1)) && st.int_clk;
    // terminal clock drives leads and sampling only in external mode, else the internal clock
    assign port_tick = (st.cur_lead.txclk == dte_port_pkg::TXC_EXTERNAL) ?
        pin_rise[2] : int_rise;
    always_comb
    begin
        case (st.cur_lead.txclk)
            // inverted clock samples at the falling edge
            dte_port_pkg::TXC_INVERT: sample_tick = int_fall;
            dte_port_pkg::TXC_EXTERNAL: sample_tick = pin_rise[2];
            default: sample_tick = int_rise;
        endcase
    end

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        next_st = st;
        // Internal transmit clock divider
        // device-generated transmit clock
        if (st.div == 3'(`PORT_CLK_HALF_CYC - 1))
        begin
            next_st.div = '0;
            next_st.int_clk = !st.int_clk;
        end
        else
            next_st.div = st.div + 3'h1;

        // Register writes
        if (bus_wr)
        begin
            case (paddr)
                `REG_LEAD_CFG: next_st.pend_lead =
                    dte_port_pkg::lead_cfg_t'(pwdata[6:0]);
                `REG_PROF_MODE:
                begin
                    next_st.prof_mode = dte_port_pkg::prof_mode_t'(pwdata[1:0]);
                    next_st.master = pwdata[`PROF_MASTER_BIT];
                end
                `REG_PROF_TIME0: next_st.prof_time[0] = to_time(pwdata);
                `REG_PROF_TIME1: next_st.prof_time[1] = to_time(pwdata);
                default:
                begin
                    if (paddr[7:4] == 4'h2)
                        next_st.pend_port[paddr[3:2]] = to_port(pwdata);
                    else if (paddr[7:4] == 4'h3)
                        next_st.prof[0][paddr[3:2]] = to_port(pwdata);
                    else if (paddr[7:4] == 4'h4)
                        next_st.prof[1][paddr[3:2]] = to_port(pwdata);
                end
            endcase
        end

        // Apply sequence with a short pause on all ports
        case (st.fsm)
            dte_port_pkg::ST_RUN:
            begin
                // pending settings go live at once
                if (apply_wr)
                begin
                    next_st.cur_lead = st.pend_lead;
                    next_st.cur_port = st.pend_port;
                    next_st.fsm = dte_port_pkg::ST_HOLD;
                    next_st.hold = 5'(`APPLY_HOLD_CYC - 1);
                end
            end
            dte_port_pkg::ST_HOLD:
            begin
                if (st.hold == 5'h00)
                    next_st.fsm = dte_port_pkg::ST_RUN;
                else
                    next_st.hold = st.hold - 5'h01;
            end
            default: next_st.fsm = dte_port_pkg::ST_RUN;
        endcase

        // Profile selection
        // profiles need master auto-configuration
        if (!st.master)
            next_st.prof_on = 1'b0;
        else
        begin
            case (st.prof_mode)
                dte_port_pkg::PM_FORCE0:
                begin
                    next_st.prof_on = 1'b1;
                    next_st.active_prof = 1'b0;
                end
                dte_port_pkg::PM_FORCE1:
                begin
                    next_st.prof_on = 1'b1;
                    next_st.active_prof = 1'b1;
                end
                dte_port_pkg::PM_TIMED:
                begin
                    // switch when time of day matches
                    if (tod_tick && (tod == st.prof_time[0]))
                    begin
                        next_st.prof_on = 1'b1;
                        next_st.active_prof = 1'b0;
                    end
                    else if (tod_tick && (tod == st.prof_time[1]))
                    begin
                        next_st.prof_on = 1'b1;
                        next_st.active_prof = 1'b1;
                    end
                end
                default: next_st.prof_on = 1'b0;
            endcase
        end
        // active profile governs the four ports
        next_st.eff_port = st.prof_on ? st.prof[st.active_prof] :
            st.cur_port;

        // Traffic gate
        // terminal-ready honoured only in idle mode
        next_st.traffic = (st.fsm == dte_port_pkg::ST_RUN) &&
            (!st.cur_lead.rdy_idle || pin_lvl[1]);
        next_st.txd_valid = sample_tick && st.traffic;
        if (sample_tick)
            next_st.txd_bit = pin_lvl[3];

        // Lead update on each port clock
        // leads refresh at the port clock edge
        if (port_tick)
        begin
            next_st.leads.cts = st.cur_lead.cs_follow ? pin_lvl[0] :
                sync_ok_i;
            case (st.cur_lead.dsr_mode)
                dte_port_pkg::DSR_OUTAGE: next_st.leads.dsr = !outage;
                dte_port_pkg::DSR_TEST: next_st.leads.dsr = !test_active_i;
                dte_port_pkg::DSR_BOTH:
                    next_st.leads.dsr = !(outage || test_active_i);
                default: next_st.leads.dsr = 1'b1;
            endcase
            next_st.leads.dcd = st.cur_lead.dcd_outage ? !outage : 1'b1;
        end

        // Read data and error captured in the setup cycle
        if (bus_setup)
        begin
            next_st.err = !addr_ok(paddr);
            next_st.rdata = '0;
            case (paddr)
                `REG_LEAD_CFG: next_st.rdata = {25'h0000000, st.pend_lead};
                `REG_STATUS: next_st.rdata = {20'h00000, pin_lvl[0],
                    pin_lvl[1], sync_ok_i, test_active_i, outage,
                    st.fsm == dte_port_pkg::ST_HOLD, st.prof_on,
                    st.active_prof, st.traffic, st.leads.dcd,
                    st.leads.dsr, st.leads.cts};
                `REG_PROF_MODE: next_st.rdata = {29'h00000000, st.master,
                    st.prof_mode};
                `REG_PROF_TIME0: next_st.rdata = from_time(st.prof_time[0]);
                `REG_PROF_TIME1: next_st.rdata = from_time(st.prof_time[1]);
                `REG_TOD: next_st.rdata = from_time(tod);
                default:
                begin
                    if (paddr[7:4] == 4'h2)
                        next_st.rdata = from_port(st.pend_port[paddr[3:2]]);
                    else if (paddr[7:4] == 4'h3)
                        next_st.rdata = from_port(st.prof[0][paddr[3:2]]);
                    else if (paddr[7:4] == 4'h4)
                        next_st.rdata = from_port(st.prof[1][paddr[3:2]]);
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            st <= '0;
            st.pend_lead <= `LEAD_CFG_RST;
            st.cur_lead <= `LEAD_CFG_RST;
            st.prof_mode <= dte_port_pkg::prof_mode_t'(`PROF_MODE_RST);
            for (int i = 0; i < 4; i++)
            begin
                st.pend_port[i].blocks <= `PORT_BLOCKS_RST;
                st.cur_port[i].blocks <= `PORT_BLOCKS_RST;
                st.eff_port[i].blocks <= `PORT_BLOCKS_RST;
                st.prof[0][i].blocks <= `PORT_BLOCKS_RST;
                st.prof[1][i].blocks <= `PORT_BLOCKS_RST;
            end
        end
        else
            st <= next_st;
    end

    // ==========================================================
    // Outputs
    assign pready = 1'b1; // Zero-wait slave
    assign pslverr = psel && penable && st.err;
    assign prdata = st.rdata;
    assign clear_to_send_lead_o = st.leads.cts;
    assign set_ready_lead_o = st.leads.dsr;
    assign carrier_detect_lead_o = st.leads.dcd;
    assign tx_clk_o = st.int_clk;
    assign txd_bit_o = st.txd_bit;
    assign txd_valid_o = st.txd_valid;
    assign port_traffic_o = st.traffic;
    assign port_cfg_o = st.eff_port;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    chk_cts_forced: assert property (
        port_tick && !st.cur_lead.cs_follow |=>
        clear_to_send_lead_o == $past(sync_ok_i))
        else $error("clear-to-send not tracking sync in forced mode");

    chk_cts_follow: assert property (
        port_tick && st.cur_lead.cs_follow |=>
        clear_to_send_lead_o == $past(pin_lvl[0]))
        else $error("clear-to-send not following request");

    chk_rdy_ignored: assert property (
        st.fsm == dte_port_pkg::ST_RUN && !st.cur_lead.rdy_idle |=>
        port_traffic_o)
        else $error("traffic stopped while terminal-ready ignored");

    chk_rdy_idle: assert property (
        st.cur_lead.rdy_idle && !pin_lvl[1] |=> !port_traffic_o ##1
        !txd_valid_o)
        else $error("traffic passed with terminal-ready off");

    chk_dsr_modes: assert property (
        port_tick && st.cur_lead.dsr_mode == dte_port_pkg::DSR_BOTH |=>
        set_ready_lead_o == !($past(outage) || $past(test_active_i)))
        else $error("set-ready wrong in combined mode");

    chk_dsr_forced: assert property (
        port_tick && st.cur_lead.dsr_mode == dte_port_pkg::DSR_FORCED |=>
        set_ready_lead_o)
        else $error("set-ready dropped in forced mode");

    chk_dcd_outage: assert property (
        port_tick && st.cur_lead.dcd_outage |=>
        carrier_detect_lead_o == !$past(outage))
        else $error("carrier-detect wrong in outage mode");

    chk_apply_pause: assert property (
        apply_wr && st.fsm == dte_port_pkg::ST_RUN |=>
        st.cur_lead == $past(st.pend_lead) ##1 !port_traffic_o [*8])
        else $error("apply did not take effect with a pause");

    chk_prof_time: assert property (
        st.master && st.prof_mode == dte_port_pkg::PM_TIMED && tod_tick
        && tod == st.prof_time[1] && tod != st.prof_time[0] |=>
        st.prof_on && st.active_prof ##1
        port_cfg_o == $past(st.prof[1], 2))
        else $error("profile did not activate at its time");

    chk_prof_off: assert property (
        !st.master |=> !st.prof_on)
        else $error("profile active without master setting");

endmodule : dte_port_leads

// ---- sim/dte_term_model.sv ----
// Terminal equipment model on the far side of the serial port
module dte_term_model (
    input wire logic run_i,
    input wire logic rts_i,
    input wire logic ready_i,
    output logic request_to_send_lead_o,
    output logic terminal_ready_lead_o,
    output logic tx_clk_ext_o,
    output logic txd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Handshake leads follow the commanded levels
    assign request_to_send_lead_o = rts_i;
    assign terminal_ready_lead_o = ready_i;
    // terminal clock returned
    // Clock stands low outside frames; data changes every falling edge
    initial
    begin
        tx_clk_ext_o = 1'b0;
        txd_o = 1'b0;
    end
    always #80 if (run_i || tx_clk_ext_o) tx_clk_ext_o = ~tx_clk_ext_o;
    always @(negedge tx_clk_ext_o) txd_o = ~txd_o;
endmodule : dte_term_model

// ---- sim/dte_port_leads_and_profiles_tb_top.sv ----
// Testbench for the port lead and profile logic
`include "dte_port_regs.svh"
module dte_port_leads_and_profiles_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i, srst_i, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic run, rts, rdy, rts_l, rdy_l, tclk, txd, nsvc, nfrm, tst, sok;
    logic cts, dsr, dcd, traffic, tck, txb, txv;
    dte_port_pkg::port_cfg_t [3:0] pcfg;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // ==========================================================
    // Clock, partner and design
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    dte_term_model u_term (.run_i(run), .rts_i(rts), .ready_i(rdy),
        .request_to_send_lead_o(rts_l), .terminal_ready_lead_o(rdy_l),
        .tx_clk_ext_o(tclk), .txd_o(txd));
    dte_port_leads #(.SEC_CYCLES(10)) u_dut (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .request_to_send_lead_i(rts_l),
        .terminal_ready_lead_i(rdy_l), .tx_clk_ext_i(tclk), .txd_i(txd),
        .network_out_of_service_i(nsvc), .network_out_of_frame_i(nfrm),
        .test_active_i(tst), .sync_ok_i(sok), .clear_to_send_lead_o(cts),
        .set_ready_lead_o(dsr), .carrier_detect_lead_o(dcd),
        .tx_clk_o(tck), .txd_bit_o(txb), .txd_valid_o(txv),
        .port_traffic_o(traffic),
        .port_cfg_o(pcfg));
    // ==========================================================
    // Shared tasks
    task give_verdict;
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    // Write the lead settings, apply them, let a port tick pass
    task cfg(input logic [31:0] v);
        apb(1'b1, `REG_LEAD_CFG, v);
        apb(1'b1, `REG_APPLY, 32'h00000001);
        repeat (30) @(posedge clk_sys_i);
    endtask : cfg
    task settle;
        repeat (30) @(posedge clk_sys_i);
    endtask : settle
    // ==========================================================
    // Scenarios
    task t_reset;
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h00000e0f);
        apb(1'b0, `REG_LEAD_CFG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({29'h0, cts, dsr, dcd}, 32'h7);
        sok <= 1'b0;
        settle();
        chk({31'h0, cts}, 32'h0);
        sok <= 1'b1;
    endtask : t_reset
    task t_outage;
        run <= 1'b1;
        nsvc <= 1'b1;
        apb(1'b1, `REG_LEAD_CFG, 32'h00000054);
        settle();
        chk({30'h0, dsr, dcd}, 32'h3);
        apb(1'b1, `REG_APPLY, 32'h00000001);
        settle();
        chk({30'h0, dsr, dcd}, 32'h0);
        nsvc <= 1'b0;
        nfrm <= 1'b1;
        settle();
        chk({30'h0, dsr, dcd}, 32'h0);
        nfrm <= 1'b0;
        settle();
        chk({30'h0, dsr, dcd}, 32'h3);
        run <= 1'b0;
    endtask : t_outage
    task t_follow;
        cfg(32'h00000008);
        tst <= 1'b1;
        settle();
        chk({31'h0, dsr}, 32'h0);
        cfg(32'h0000000f);
        chk({31'h0, dsr}, 32'h0);
        tst <= 1'b0;
        rts <= 1'b0;
        rdy <= 1'b0;
        settle();
        chk({30'h0, cts, traffic}, 32'h0);
        rts <= 1'b1;
        rdy <= 1'b1;
        settle();
        chk({29'h0, cts, dsr, traffic}, 32'h7);
        cfg(32'h00000000);
        rdy <= 1'b0;
        settle();
        chk({31'h0, traffic}, 32'h1);
    endtask : t_follow
    // Count sample pulses by transmit clock phase and data bit changes
    task count_pulses(input int n, output int hi, output int lo,
        output int tg);
        logic last;
        hi = 0;
        lo = 0;
        tg = 0;
        @(negedge clk_sys_i);
        last = txb;
        repeat (n)
        begin
            @(negedge clk_sys_i);
            hi += int'(txv && tck);
            lo += int'(txv && !tck);
            tg += int'(txb !== last);
            last = txb;
        end
        @(posedge clk_sys_i);
    endtask : count_pulses
    task t_data;
        int hi, lo, tg;
        cfg(32'h00000000);
        count_pulses(80, hi, lo, tg);
        chk({hi[15:0], lo[15:0]}, 32'h000a0000);
        cfg(32'h00000020);
        count_pulses(80, hi, lo, tg);
        chk({hi[15:0], lo[15:0]}, 32'h0000000a);
        run <= 1'b1;
        cfg(32'h00000040);
        count_pulses(160, hi, lo, tg);
        chk({hi[15:0] + lo[15:0], tg[15:0]}, 32'h00140014);
        run <= 1'b0;
    endtask : t_data
    task t_profile;
        apb(1'b1, `REG_PROF1_PORT0, 32'h000001c8);
        apb(1'b0, `REG_PROF1_PORT0, 32'h0);
        chk(rd, 32'h0000018c);
        apb(1'b1, `REG_PROF0_PORT0, 32'h00000100);
        apb(1'b0, `REG_PROF0_PORT0, 32'h0);
        chk(rd, 32'h00000101);
        apb(1'b1, `REG_PROF_MODE, 32'h00000002);
        settle();
        chk({23'h0, pcfg[0]}, 32'h00000001);
        apb(1'b1, `REG_PROF_MODE, 32'h00000006);
        settle();
        chk({23'h0, pcfg[0]}, 32'h0000018c);
        apb(1'b1, `REG_PROF_MODE, 32'h00000005);
        settle();
        chk({23'h0, pcfg[0]}, 32'h00000101);
        apb(1'b1, `REG_MAN_PORT0, 32'h00000105);
        apb(1'b1, `REG_APPLY, 32'h00000001);
        apb(1'b1, `REG_PROF_MODE, 32'h00000007);
        settle();
        chk({23'h0, pcfg[0]}, 32'h00000105);
        apb(1'b1, `REG_PROF_TIME1, 32'h00000003);
        apb(1'b1, `REG_PROF_TIME0, 32'h00000009);
        apb(1'b1, `REG_TOD, 32'h00000000);
        apb(1'b1, `REG_PROF_MODE, 32'h00000004);
        repeat (10) @(posedge clk_sys_i);
        chk({23'h0, pcfg[0]}, 32'h00000105);
        settle();
        chk({23'h0, pcfg[0]}, 32'h0000018c);
        settle();
        chk({23'h0, pcfg[0]}, 32'h0000018c);
        settle();
        chk({23'h0, pcfg[0]}, 32'h00000101);
    endtask : t_profile
    // ==========================================================
    // Main sequence and timeout
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    initial
    begin
        {srst_i, psel, penable, pwrite, paddr, pwdata} = '1;
        {psel, penable, pwrite, paddr, pwdata, run, nsvc, nfrm, tst} = '0;
        {rts, rdy, sok} = 3'h7;
        repeat (5) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        settle();
        t_reset();
        t_outage();
        t_follow();
        t_data();
        t_profile();
        give_verdict();
    end
endmodule : dte_port_leads_and_profiles_tb_top
